// ---- src/bfs_pkg.sv ----
// Constants for the bias fault and device condition flag bank
// Overview of operation
// - A detected LED string short to ground sets fault bit 5, which stays latched and blocks the backlight converter from starting.
// - Undervoltage on the positive bias output sets fault bit 4 at once and switches that output off after 50 ms of persistence.
// - An overload or overcurrent on the positive bias output sets fault bit 3.
// - Undervoltage on the negative bias output sets fault bit 2 at once and switches it off after 50 ms of persistence.
// - Undervoltage on the gate high rail sets fault bit 1 at once and switches the rail off after 50 ms of persistence.
// - Undervoltage on the gate low rail sets fault bit 0 at once and switches the rail off after 50 ms of persistence.
// - Status bit 3 reads 1 after every power-on reset.
// - Reading the device condition register clears the power-on indicator until the next reset.
// - Status bit 2 shows whether the backlight driver is in thermal shutdown.
// - Status bit 1 shows whether the backlight driver is at or above its warning temperature.
// - Status bit 0 shows whether the bias section is in thermal shutdown.
// - Each fault flag has a mask bit; an unmasked set flag pulls the active-low fault pin low.
package bfs_pkg;
   localparam int          REG_W            = 8;
   localparam int          ADDR_W           = 8;
   localparam int          COND_W           = 9;
   localparam int          UV_N             = 4;
   localparam logic [7:0]  ADDR_FAULT       = 8'h08;
   localparam logic [7:0]  ADDR_COND        = 8'h09;
   localparam logic [7:0]  ADDR_MASK        = 8'h0b;
   // Fault bit positions, also used as condition input positions
   localparam int          FLT_SHORT_GND    = 5;
   localparam int          FLT_POS_UV       = 4;
   localparam int          FLT_POSITIVE_OUTPUT_OVERLOAD_FLAG       = 3;
   localparam int          FLT_NEG_UV       = 2;
   localparam int          FLT_GATE_HI_UV   = 1;
   localparam int          FLT_GATE_LO_UV   = 0;
   localparam int          FLT_W            = 6;
   // Thermal condition input positions
   localparam int          CND_BIAS_TOFF    = 6;
   localparam int          CND_BL_TWARN     = 7;
   localparam int          CND_BL_TOFF      = 8;
   // Device condition register bit positions
   localparam int          ST_POWER_ON      = 3;
   localparam int          ST_BL_TOFF       = 2;
   localparam int          ST_BL_TWARN      = 1;
   localparam int          ST_BIAS_TOFF     = 0;
   localparam logic [5:0]  FLT_RESET        = 6'h00;
   localparam logic [5:0]  MASK_RESET       = 6'h00;
   localparam logic [5:0]  FLT_CLR_ON_READ  = 6'h1f;
   localparam logic [7:0]  RD_ZERO          = 8'h00;
   // Undervoltage persistence time
   localparam int          UV_PERSIST_MS    = 50;
   localparam int          CLK_HZ           = 100_000_000;
   localparam int          UV_PERSIST_CYC   = UV_PERSIST_MS * (CLK_HZ / 1000);
endpackage

// ---- src/bfs_flag_bank.sv ----
// Bias fault flags, device condition flags, undervoltage shutdown timers and fault pin
`timescale 1ns/100ps
`default_nettype none
module bfs_flag_bank #(
   parameter int UV_OFF_CYCLES = bfs_pkg::UV_PERSIST_CYC
) (
   input  wire logic                       clk_sys_in,
   input  wire logic                       reset_in,
   input  wire logic [bfs_pkg::COND_W-1:0] cond_pins_in,
   input  wire logic                       rd_en_in,
   input  wire logic [bfs_pkg::ADDR_W-1:0] rd_addr_in,
   input  wire logic                       wr_en_in,
   input  wire logic [bfs_pkg::ADDR_W-1:0] wr_addr_in,
   input  wire logic [bfs_pkg::REG_W-1:0]  wr_data_in,
   output logic      [bfs_pkg::REG_W-1:0]  rd_data_out,
   output logic                            fault_output_pin_n_out,
   output logic                            backlight_start_block_out,
   output logic                            positive_output_off_out,
   output logic                            negative_output_off_out,
   output logic                            gate_high_off_out,
   output logic                            gate_low_off_out
);
   import bfs_pkg::*;

   localparam int CNT_W = $clog2(UV_OFF_CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(UV_OFF_CYCLES - 1);
   localparam logic [CNT_W-1:0] CNT_ZERO = '0;
   localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

   // Maps timer slot to the fault bit it guards
   function automatic int uv_bit(input int slot);
      case (slot)
         0:       uv_bit = FLT_POS_UV;
         1:       uv_bit = FLT_NEG_UV;
         2:       uv_bit = FLT_GATE_HI_UV;
         default: uv_bit = FLT_GATE_LO_UV;
      endcase
   endfunction

   function automatic logic hit(input logic en, input logic [ADDR_W-1:0] a,
                                input logic [ADDR_W-1:0] target);
      hit = en && (a == target);
   endfunction

   logic [COND_W-1:0] sync1_q;
   logic [COND_W-1:0] sync2_q;
   logic [COND_W-1:0] sync3_q;
   logic [COND_W-1:0] cond_q;
   logic [FLT_W-1:0]  flags_q;
   logic [FLT_W-1:0]  flags_d;
   logic [FLT_W-1:0]  mask_q;
   logic              power_on_seen_flag_q;
   logic [CNT_W-1:0]  uv_cnt_q [UV_N];
   logic [UV_N-1:0]   off_q;
   logic              rd_fault;
   logic              rd_cond;

   assign rd_fault = hit(rd_en_in, rd_addr_in, ADDR_FAULT);
   assign rd_cond  = hit(rd_en_in, rd_addr_in, ADDR_COND);

   // Pins are asynchronous; a change counts only once stages two and three agree
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         sync1_q <= '0;
         sync2_q <= '0;
         sync3_q <= '0;
         cond_q  <= '0;
      end else begin
         sync1_q <= cond_pins_in;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         for (int i = 0; i < COND_W; i++) begin
            if (sync2_q[i] == sync3_q[i]) begin
               cond_q[i] <= sync3_q[i];
            end
         end
      end
   end

   // Sticky flags: reading the fault register clears bits 4..0, but a live condition
   // sets them again in the same cycle so no event is lost. Bit 5 stays until reset.
   always_comb begin
      flags_d = flags_q;
      if (rd_fault) begin
         flags_d = flags_q & ~FLT_CLR_ON_READ;
      end
      flags_d[FLT_SHORT_GND]  = flags_d[FLT_SHORT_GND]  | cond_q[FLT_SHORT_GND];
      flags_d[FLT_POS_UV]     = flags_d[FLT_POS_UV]     | cond_q[FLT_POS_UV];
      flags_d[FLT_POSITIVE_OUTPUT_OVERLOAD_FLAG]     = flags_d[FLT_POSITIVE_OUTPUT_OVERLOAD_FLAG]     | cond_q[FLT_POSITIVE_OUTPUT_OVERLOAD_FLAG];
      flags_d[FLT_NEG_UV]     = flags_d[FLT_NEG_UV]     | cond_q[FLT_NEG_UV];
      flags_d[FLT_GATE_HI_UV] = flags_d[FLT_GATE_HI_UV] | cond_q[FLT_GATE_HI_UV];
      flags_d[FLT_GATE_LO_UV] = flags_d[FLT_GATE_LO_UV] | cond_q[FLT_GATE_LO_UV];
   end

   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         flags_q <= FLT_RESET;
      end else begin
         flags_q <= flags_d;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         backlight_start_block_out <= 1'b0;
      end else begin
         backlight_start_block_out <= flags_d[FLT_SHORT_GND];
      end
   end

   // Persistence timers; once an output is off it stays off until reset
   for (genvar g = 0; g < UV_N; g++) begin : g_uv
      always_ff @(posedge clk_sys_in) begin
         if (reset_in) begin
            uv_cnt_q[g] <= CNT_ZERO;
            off_q[g]    <= 1'b0;
         end else if (!cond_q[uv_bit(g)]) begin
            uv_cnt_q[g] <= CNT_ZERO;
         end else if (!off_q[g]) begin
            if (uv_cnt_q[g] == CNT_LAST) begin
               off_q[g] <= 1'b1;
            end else begin
               uv_cnt_q[g] <= uv_cnt_q[g] + CNT_ONE;
            end
         end
      end
   end

   assign positive_output_off_out = off_q[0];
   assign negative_output_off_out = off_q[1];
   assign gate_high_off_out       = off_q[2];
   assign gate_low_off_out        = off_q[3];

   // Only reset sets the power-on indicator, so the read clear needs no arbitration
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         power_on_seen_flag_q <= 1'b1;
      end else if (rd_cond) begin
         power_on_seen_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         mask_q <= MASK_RESET;
      end else if (hit(wr_en_in, wr_addr_in, ADDR_MASK)) begin
         mask_q <= wr_data_in[FLT_W-1:0];
      end
   end

   // Uses next flag state so the pin falls in the same cycle the flag is set
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         fault_output_pin_n_out <= 1'b1;
      end else begin
         fault_output_pin_n_out <= ~|(flags_d & ~mask_q);
      end
   end

   // Read data is registered; it appears one cycle after the strobe
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         rd_data_out <= RD_ZERO;
      end else if (rd_fault) begin
         rd_data_out <= {2'h0, flags_q};
      end else if (rd_cond) begin
         rd_data_out                <= RD_ZERO;
         rd_data_out[ST_POWER_ON]   <= power_on_seen_flag_q;
         rd_data_out[ST_BL_TOFF]    <= cond_q[CND_BL_TOFF];
         rd_data_out[ST_BL_TWARN]   <= cond_q[CND_BL_TWARN];
         rd_data_out[ST_BIAS_TOFF]  <= cond_q[CND_BIAS_TOFF];
      end else if (hit(rd_en_in, rd_addr_in, ADDR_MASK)) begin
         rd_data_out <= {2'h0, mask_q};
      end else if (rd_en_in) begin
         rd_data_out <= RD_ZERO;
      end
   end

   sequence cond_read_s;
      rd_en_in && (rd_addr_in == ADDR_COND);
   endsequence

   sequence power_on_cleared_s;
      ##1 !power_on_seen_flag_q ##1 !power_on_seen_flag_q;
   endsequence

   // Register bus strobes as seen at this bank's ports
   sequence fault_read_s;
      rd_en_in && (rd_addr_in == ADDR_FAULT);
   endsequence

   sequence mask_read_s;
      rd_en_in && (rd_addr_in == ADDR_MASK);
   endsequence

   sequence mask_write_s;
      wr_en_in && (wr_addr_in == ADDR_MASK);
   endsequence

   shortgnd_latch_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      cond_q[FLT_SHORT_GND] |=> flags_q[FLT_SHORT_GND] && backlight_start_block_out
         ##1 flags_q[FLT_SHORT_GND])
      else $error("short to ground flag not latched");
   posuv_set_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      cond_q[FLT_POS_UV] |=> flags_q[FLT_POS_UV])
      else $error("positive undervoltage flag not set");
   posol_set_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      $rose(cond_q[FLT_POSITIVE_OUTPUT_OVERLOAD_FLAG]) |=> flags_q[FLT_POSITIVE_OUTPUT_OVERLOAD_FLAG])
      else $error("positive overload flag not set");
   neguv_set_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      cond_q[FLT_NEG_UV] |=> flags_q[FLT_NEG_UV])
      else $error("negative undervoltage flag not set");
   gate_hi_set_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      cond_q[FLT_GATE_HI_UV] |=> flags_q[FLT_GATE_HI_UV])
      else $error("gate high rail undervoltage flag not set");
   gate_lo_set_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      cond_q[FLT_GATE_LO_UV] |=> flags_q[FLT_GATE_LO_UV])
      else $error("gate low rail undervoltage flag not set");
   uv_timeout_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      (cond_q[FLT_POS_UV] && uv_cnt_q[0] == CNT_LAST && !off_q[0]) |=>
         positive_output_off_out)
      else $error("positive output not switched off at timeout");
   uv_restart_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      !cond_q[FLT_NEG_UV] |=> uv_cnt_q[1] == CNT_ZERO && !$rose(negative_output_off_out))
      else $error("persistence timer did not restart");
   por_indicator_a: assert property (@(posedge clk_sys_in)
      reset_in |=> power_on_seen_flag_q)
      else $error("power-on indicator not set after reset");
   por_clear_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      cond_read_s |-> power_on_cleared_s)
      else $error("power-on indicator not cleared by read");
   thermal_bits_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      cond_read_s |=> rd_data_out[ST_BL_TOFF] == $past(cond_q[CND_BL_TOFF])
         && rd_data_out[ST_BL_TWARN] == $past(cond_q[CND_BL_TWARN])
         && rd_data_out[ST_BIAS_TOFF] == $past(cond_q[CND_BIAS_TOFF]))
      else $error("thermal status bits wrong");
   fault_pin_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      ##1 fault_output_pin_n_out == !(|(flags_q & ~$past(mask_q))))
      else $error("fault pin does not match masked flags");
   upper_zero_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      cond_read_s |=> rd_data_out[7:4] == 4'h0)
      else $error("unused status bits not zero");

   // Each output's timer: shutdown at expiry, restart when the condition drops
   neg_timeout_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      (cond_q[FLT_NEG_UV] && uv_cnt_q[1] == CNT_LAST && !off_q[1]) |=>
         negative_output_off_out)
      else $error("negative output not switched off at timeout");
   gate_hi_timeout_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      (cond_q[FLT_GATE_HI_UV] && uv_cnt_q[2] == CNT_LAST && !off_q[2]) |=>
         gate_high_off_out)
      else $error("gate high rail not switched off at timeout");
   gate_lo_timeout_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      (cond_q[FLT_GATE_LO_UV] && uv_cnt_q[3] == CNT_LAST && !off_q[3]) |=>
         gate_low_off_out)
      else $error("gate low rail not switched off at timeout");
   pos_restart_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      !cond_q[FLT_POS_UV] |=> uv_cnt_q[0] == CNT_ZERO && !$rose(positive_output_off_out))
      else $error("positive timer did not restart");
   gate_hi_restart_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      !cond_q[FLT_GATE_HI_UV] |=> uv_cnt_q[2] == CNT_ZERO && !$rose(gate_high_off_out))
      else $error("gate high timer did not restart");
   gate_lo_restart_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      !cond_q[FLT_GATE_LO_UV] |=> uv_cnt_q[3] == CNT_ZERO && !$rose(gate_low_off_out))
      else $error("gate low timer did not restart");
   off_sticky_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      ##1 ((off_q & $past(off_q)) == $past(off_q)))
      else $error("switched off output came back on");

   // A read clears flags 4..0 only once the condition has gone; flag 5 never
   set_wins_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      (rd_fault && cond_q[FLT_POS_UV]) |=> flags_q[FLT_POS_UV])
      else $error("live undervoltage lost on read");
   posol_hold_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      (flags_q[FLT_POSITIVE_OUTPUT_OVERLOAD_FLAG] && !rd_fault) |=> flags_q[FLT_POSITIVE_OUTPUT_OVERLOAD_FLAG])
      else $error("overload flag dropped without a read");
   shortgnd_read_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      (rd_fault && flags_q[FLT_SHORT_GND]) |=> flags_q[FLT_SHORT_GND])
      else $error("short to ground flag cleared by read");
   fault_read_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      fault_read_s |=> rd_data_out == {2'h0, $past(flags_q)})
      else $error("fault register read data wrong");
   block_hold_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      backlight_start_block_out |=> backlight_start_block_out)
      else $error("backlight start block released");

   // Power-on indicator and mask register
   por_stays_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      !power_on_seen_flag_q |=> !power_on_seen_flag_q)
      else $error("power-on indicator set without reset");
   cond_power_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      cond_read_s |=> rd_data_out[ST_POWER_ON] == $past(power_on_seen_flag_q))
      else $error("power-on bit wrong in status read");
   mask_write_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      mask_write_s |=> mask_q == $past(wr_data_in[FLT_W-1:0]))
      else $error("mask write not taken");
   mask_read_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      mask_read_s |=> rd_data_out == {2'h0, $past(mask_q)})
      else $error("mask read data wrong");
   pin_masked_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      (&mask_q) |=> fault_output_pin_n_out)
      else $error("fault pin low with all flags masked");
   pin_shortgnd_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      (flags_q[FLT_SHORT_GND] && !mask_q[FLT_SHORT_GND]) |=> !fault_output_pin_n_out)
      else $error("fault pin high with unmasked short flag");
endmodule
`default_nettype wire

// ---- verif/bfs_host_model.sv ----
// Host side of the flag bank register bus
`timescale 1ns/100ps
`default_nettype none
module bfs_host_model (
   input  wire logic       clk_sys_in,
   input  wire logic       go_in,
   input  wire logic       wr_in,
   input  wire logic [7:0] addr_in,
   input  wire logic [7:0] data_in,
   output logic            rd_en_out = 1'b0,
   output logic            wr_en_out = 1'b0,
   output logic      [7:0] addr_out  = 8'h00,
   output logic      [7:0] data_out  = 8'h00
);
   // Idle lines flip every cycle so a design that samples them outside a strobe is caught
   always @(posedge clk_sys_in) begin
      rd_en_out <= go_in & ~wr_in;
      wr_en_out <= go_in & wr_in;
      addr_out  <= go_in ? addr_in : ~addr_out;
      data_out  <= go_in ? data_in : ~data_out;
   end
endmodule
`default_nettype wire

// ---- verif/test_bias_fault_status_flags.sv ----
// Self-checking bench for the bias fault and condition flag bank
`timescale 1ns/100ps
`default_nettype none
module test_bias_fault_status_flags;
   import bfs_pkg::*;
   localparam int     UV_T = 20;
   logic              clk_sys_in = 1'b0;
   logic              reset_in   = 1'b1;
   logic [COND_W-1:0] cond = '0;
   logic              go = 1'b0;
   logic              wr = 1'b0;
   logic [7:0]        addr = 8'h00;
   logic [7:0]        data = 8'h00;
   logic              rd_en, wr_en, pin_n, bl_block;
   logic [7:0]        bus_a, bus_d, rd_data, d, m;
   logic [3:0]        off, exp_off;
   logic [5:0]        flt_m;
   logic [31:0]       rnd = 32'h60ccfb29;
   int                errors = 0;
   int                checked = 0;
   always #5 clk_sys_in = ~clk_sys_in;
   bfs_host_model host (.clk_sys_in(clk_sys_in), .go_in(go), .wr_in(wr), .addr_in(addr),
      .data_in(data), .rd_en_out(rd_en), .wr_en_out(wr_en), .addr_out(bus_a),
      .data_out(bus_d));
   bfs_flag_bank #(.UV_OFF_CYCLES(UV_T)) dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
      .cond_pins_in(cond), .rd_en_in(rd_en), .rd_addr_in(bus_a), .wr_en_in(wr_en),
      .wr_addr_in(bus_a), .wr_data_in(bus_d), .rd_data_out(rd_data),
      .fault_output_pin_n_out(pin_n), .backlight_start_block_out(bl_block),
      .positive_output_off_out(off[3]), .negative_output_off_out(off[2]),
      .gate_high_off_out(off[1]), .gate_low_off_out(off[0]));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task chk(input string n, input logic [7:0] s, input logic [7:0] e);
      checked++;
      if (s !== e) begin
         errors++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Host strobe lands one edge after go; read data stands from the edge after that
   task acc(input logic w, input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_sys_in);
      go <= 1'b1;
      wr <= w;
      addr <= a;
      data <= v;
      @(posedge clk_sys_in);
      go <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
      #1 d = rd_data;
   endtask
   task rchk(input string n, input logic [7:0] a, input logic [7:0] e);
      acc(1'b0, a, 8'h00);
      chk(n, d, e);
   endtask
   // Three-flop filter plus flag stage, with margin
   task settle;
      repeat (6) @(posedge clk_sys_in);
      #1;
   endtask
   initial begin
      repeat (100000) @(posedge clk_sys_in);
      errors++;
      end_sim();
   end
   initial begin
      repeat (12) @(posedge clk_sys_in);
      reset_in <= 1'b0;
      rchk("cond", ADDR_COND, 8'h08);
      rchk("cond", ADDR_COND, 8'h00);
      rchk("fault", ADDR_FAULT, 8'h00);
      chk("pin", {7'h00, pin_n}, 8'h01);
      $display("test power-on done");
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_sys_in) cond <= {i[2:0], 6'h00};
         settle();
         rchk("cond", ADDR_COND, {5'h00, i[2:0]});
      end
      acc(1'b1, ADDR_COND, 8'hff);
      rchk("cond", ADDR_COND, 8'h07);
      $display("test thermal done");
      flt_m = 6'h00;
      for (int b = 0; b < 6; b++) begin
         rnd = lfsr(rnd);
         @(posedge clk_sys_in) cond <= COND_W'(1) << b;
         // Random pulse stays well under the timeout
         repeat (4 + rnd[2:0]) @(posedge clk_sys_in);
         cond <= '0;
         settle();
         chk("pin", {7'h00, pin_n}, 8'h00);
         rchk("fault", ADDR_FAULT, {2'b00, flt_m | 6'(1 << b)});
         if (b == 5)
            flt_m[5] = 1'b1;
         rchk("fault", ADDR_FAULT, {2'b00, flt_m});
         chk("off", {4'h0, off}, 8'h00);
      end
      chk("block", {7'h00, bl_block}, 8'h01);
      $display("test flags done");
      exp_off = 4'h0;
      for (int k = 0; k < 4; k++) begin
         @(posedge clk_sys_in) cond <= COND_W'(1) << ((k == 3) ? 4 : k);
         repeat (UV_T - 5) @(posedge clk_sys_in);
         cond <= '0;
         settle();
         chk("off", {4'h0, off}, {4'h0, exp_off});
         @(posedge clk_sys_in) cond <= COND_W'(1) << ((k == 3) ? 4 : k);
         repeat (UV_T + 10) @(posedge clk_sys_in);
         #1 exp_off[k] = 1'b1;
         chk("off", {4'h0, off}, {4'h0, exp_off});
      end
      $display("test timeout done");
      @(posedge clk_sys_in) cond <= 9'h03f;
      settle();
      acc(1'b1, ADDR_FAULT, 8'h00);
      rchk("fault", ADDR_FAULT, 8'h3f);
      rchk("unmapped", 8'h0c, 8'h00);
      for (int j = 0; j < 6; j++) begin
         rnd = lfsr(rnd);
         m = (j == 0) ? 8'hff : rnd[7:0];
         acc(1'b1, ADDR_MASK, m);
         rchk("mask", ADDR_MASK, {2'b00, m[5:0]});
         chk("pin", {7'h00, pin_n}, {7'h00, &m[5:0]});
      end
      $display("test mask done");
      @(posedge clk_sys_in) reset_in <= 1'b1;
      repeat (12) @(posedge clk_sys_in);
      reset_in <= 1'b0;
      rchk("cond", ADDR_COND, 8'h08);
      $display("test second reset done");
      end_sim();
   end
endmodule
`default_nettype wire
